/* File: inc/bma_pkg.sv */
/*
 * Constants for the banked memory address map: program counter widths,
 * vectors, data memory banking, core register offsets and status bit positions.
 * Assumes a single clock domain and a core that drives one access per cycle.
 */
package bma_pkg;
    // Program side.
    localparam int PC_WIDTH = 13;
    localparam int PROG_IMPL_WIDTH = 11;
    localparam logic [12:0] RESET_VECTOR = 13'h0000;
    localparam logic [12:0] INTR_VECTOR = 13'h0004;
    // Data side.
    localparam int BANK_ADDR_WIDTH = 7;
    localparam int DATA_ADDR_WIDTH = 9;
    localparam int GENERAL_RAM_WORDS = 128;
    localparam logic [6:0] SPECIAL_REGISTER_TOP = 7'h1f;
    localparam logic [6:0] COMMON_BASE = 7'h70;
    localparam logic [6:0] BANK1_GENERAL_RAM_LAST = 7'h3f;
    // Core register offsets within a bank.
    localparam logic [6:0] OFS_INDIRECT_ACCESS_PORT = 7'h00;
    localparam logic [6:0] OFS_PROGRAM_COUNTER_LOW = 7'h02;
    localparam logic [6:0] OFS_CORE_STATUS = 7'h03;
    localparam logic [6:0] OFS_INDIRECT_POINTER = 7'h04;
    // Status bit positions.
    localparam int ST_INDIRECT_BANK_BIT = 7;
    localparam int ST_BANK_SELECT_HIGH = 6;
    localparam int ST_BANK_SELECT_LOW = 5;
    // Reset values.
    localparam logic [7:0] STATUS_RESET = 8'h18;
    localparam logic [7:0] POINTER_RESET = 8'h00;
endpackage : bma_pkg

/* File: rtl/bma_data_decode.sv */
/*
 * Pure decode of a 9-bit data address into a general RAM index.
 * Assumes the caller has already removed core register locations.
 */
module bma_data_decode
    import bma_pkg::*;
(
    // Address in.
    input wire logic [8:0] i_addr,
    // Decode out.
    output logic o_hit,
    output logic [6:0] o_index
);
    logic [1:0] bank;
    logic [6:0] ofs;

    // Banks 1 to 3 top window and bank 0 RAM share one index space.
    always_comb begin
        bank = i_addr[8:7];
        ofs = i_addr[6:0];
        o_hit = 1'b0;
        o_index = 7'h00;
        if (ofs >= COMMON_BASE) begin
            o_hit = 1'b1;
            o_index = ofs;
        end else if (bank == 2'h0 && ofs > SPECIAL_REGISTER_TOP) begin
            o_hit = 1'b1;
            o_index = ofs;
        end else if (bank == 2'h1 && ofs > SPECIAL_REGISTER_TOP && ofs <= BANK1_GENERAL_RAM_LAST) begin
            // Bank 1 RAM reuses the free indices 00h-1Fh of the bank 0 space.
            o_hit = 1'b1;
            o_index = ofs - 7'h20;
        end
    end
endmodule : bma_data_decode

/* File: rtl/bma_address_map.sv */
/*
 * Program counter and banked data memory map with core registers and RAM.
 * The counter feeds an 11-bit fetch address; data accesses are decoded into the
 * shared status, pointer and counter low byte, the general RAM or peripheral space.
 * Assumes the core presents one data access per cycle and reads data combinationally
 * from registered state; peripheral registers live outside this block.
 * The core waits one cycle for read data, which stands until the next access.
 */
module bma_address_map
    import bma_pkg::*;
(
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_reset,
    // Program counter control.
    input wire logic i_pc_advance,
    input wire logic i_pc_load,
    input wire logic [12:0] i_pc_target,
    input wire logic i_intr_accept,
    // Data access from the core.
    input wire logic i_access_en,
    input wire logic i_write_en,
    input wire logic [6:0] i_opcode_addr,
    input wire logic [7:0] i_write_data,
    // Program side outputs.
    output logic [12:0] o_pc,
    output logic [10:0] o_fetch_addr,
    // Data side outputs.
    output logic [7:0] o_read_data,
    output logic [8:0] o_eff_addr,
    output logic [7:0] o_core_status,
    output logic o_periph_sel
);
    typedef struct packed {
        // Program side.
        logic [12:0] pc;
        // Core registers, one copy shared by every bank.
        logic [7:0] status;
        logic [7:0] pointer;
        // Registered answer of the last data access.
        logic [7:0] rdata;
        logic [8:0] eff;
        logic periph;
        // General RAM: bank 0 bytes, with the bank 1 bytes folded into the free low indices.
        logic [GENERAL_RAM_WORDS-1:0][7:0] ram;
    } bma_state_t;

    // Effective data address: offset zero takes the pointer and the indirect bank bit,
    // any other offset takes the two bank-select bits above the opcode offset.
    function automatic logic [8:0] form_eff_addr(input logic [7:0] status, input logic [7:0] pointer,
                                                 input logic [6:0] ofs);
        logic [8:0] result;
        if (ofs == OFS_INDIRECT_ACCESS_PORT) begin
            result = {status[ST_INDIRECT_BANK_BIT], pointer};
        end else begin
            result = {status[ST_BANK_SELECT_HIGH], status[ST_BANK_SELECT_LOW], ofs};
        end
        return result;
    endfunction : form_eff_addr

    // Program counter step. The carry is cut on purpose, so the top word wraps to zero.
    function automatic logic [12:0] step_pc(input logic [12:0] pc);
        logic [13:0] sum;
        sum = {1'b0, pc} + 14'h0001;
        return sum[12:0];
    endfunction : step_pc

    // Program counter control priority: interrupt over load, load over step.
    function automatic logic [12:0] select_pc(input logic [12:0] pc, input logic adv, input logic load,
                                              input logic [12:0] target, input logic intr);
        logic [12:0] result;
        result = pc;
        if (intr) begin
            result = INTR_VECTOR;
        end else if (load) begin
            result = target;
        end else if (adv) begin
            result = step_pc(pc);
        end
        return result;
    endfunction : select_pc

    // A write to the low byte replaces bits 7:0 only; the upper five bits of the counter stay.
    function automatic logic [12:0] load_pc_low(input logic [12:0] pc, input logic [7:0] wdata);
        return {pc[12:8], wdata};
    endfunction : load_pc_low

    // Status write merge. Only the bank and indirect bits follow the core; the flag bits keep
    // their value because the arithmetic unit owns them, and a stray write must not corrupt them.
    function automatic logic [7:0] merge_status(input logic [7:0] old_status, input logic [7:0] wdata);
        logic [7:0] result;
        result = old_status;
        result[ST_INDIRECT_BANK_BIT] = wdata[ST_INDIRECT_BANK_BIT];
        result[ST_BANK_SELECT_HIGH] = wdata[ST_BANK_SELECT_HIGH];
        result[ST_BANK_SELECT_LOW] = wdata[ST_BANK_SELECT_LOW];
        return result;
    endfunction : merge_status

    // Offsets that hold a core register; these ignore the bank bits.
    function automatic logic is_core_offset(input logic [6:0] ofs);
        logic result;
        unique case (ofs)
            OFS_INDIRECT_ACCESS_PORT, OFS_PROGRAM_COUNTER_LOW, OFS_CORE_STATUS, OFS_INDIRECT_POINTER: begin
                result = 1'b1;
            end
            default: begin
                result = 1'b0;
            end
        endcase
        return result;
    endfunction : is_core_offset

    // Offsets below the general RAM that are not core registers belong to a peripheral outside.
    function automatic logic is_peripheral_offset(input logic [6:0] ofs);
        return (ofs <= SPECIAL_REGISTER_TOP) && !is_core_offset(ofs);
    endfunction : is_peripheral_offset

    // Registered state and its next value.
    bma_state_t st_reg;
    bma_state_t st_next;
    // Address path into the RAM decoder.
    logic [8:0] addr;
    logic ram_hit;
    logic [6:0] ram_index;

    // Effective address: location zero redirects through the pointer.
    always_comb begin
        addr = form_eff_addr(st_reg.status, st_reg.pointer, i_opcode_addr);
    end

    bma_data_decode u_decode (
        .i_addr(addr),
        .o_hit(ram_hit),
        .o_index(ram_index)
    );

    // Next state: program counter, core registers, RAM and read data.
    always_comb begin
        st_next = st_reg;
        st_next.periph = 1'b0;
        // Program counter controls; a low-byte write below overrides them in the same cycle.
        st_next.pc = select_pc(st_reg.pc, i_pc_advance, i_pc_load, i_pc_target, i_intr_accept);
        // Data access: the answer is registered and shows right after the taking edge.
        if (i_access_en) begin
            st_next.eff = addr;
            st_next.rdata = 8'h00;
            // Core registers ignore the bank bits, so every bank sees the same copy.
            unique case (addr[6:0])
                OFS_PROGRAM_COUNTER_LOW: begin
                    st_next.rdata = st_reg.pc[7:0];
                    if (i_write_en) begin
                        st_next.pc = load_pc_low(st_reg.pc, i_write_data);
                    end
                end
                OFS_CORE_STATUS: begin
                    st_next.rdata = st_reg.status;
                    if (i_write_en) begin
                        // Only the bank and indirect bits are writable here.
                        st_next.status = merge_status(st_reg.status, i_write_data);
                    end
                end
                OFS_INDIRECT_POINTER: begin
                    st_next.rdata = st_reg.pointer;
                    if (i_write_en) begin
                        st_next.pointer = i_write_data;
                    end
                end
                OFS_INDIRECT_ACCESS_PORT: begin
                    st_next.rdata = 8'h00; // pointer aimed at the access port reads zero.
                end
                default: begin
                    // Read before write, so a byte written now shows on the next access.
                    if (ram_hit) begin
                        st_next.rdata = st_reg.ram[ram_index];
                        if (i_write_en) begin
                            st_next.ram[ram_index] = i_write_data;
                        end
                    end else if (is_peripheral_offset(addr[6:0])) begin
                        // Peripheral space is served outside; writes to unimplemented space are dropped.
                        st_next.periph = 1'b1;
                    end
                end
            endcase
        end
    end

    // Single register stage; RAM keeps its contents over reset.
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            st_reg.pc <= RESET_VECTOR;
            st_reg.status <= STATUS_RESET;
            st_reg.pointer <= POINTER_RESET;
            st_reg.rdata <= 8'h00;
            st_reg.eff <= 9'h000;
            st_reg.periph <= 1'b0;
            // RAM holds its contents; a write offered during reset is ignored.
            st_reg.ram <= st_reg.ram;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs from registered state.
    assign o_pc = st_reg.pc;
    assign o_fetch_addr = st_reg.pc[PROG_IMPL_WIDTH-1:0];
    assign o_read_data = st_reg.rdata;
    assign o_eff_addr = st_reg.eff;
    assign o_core_status = st_reg.status;
    assign o_periph_sel = st_reg.periph;
endmodule : bma_address_map

/* File: tb/bma_core_model.sv */
/* Core-side model: drives the map's program counter controls and data accesses.
   Assumes the bench calls one task at a time. */
module bma_core_model (
    // Clock.
    input wire logic i_ref_clk,
    // Program counter controls.
    output logic o_adv,
    output logic o_ld,
    output logic o_intr,
    output logic [12:0] o_tgt,
    // Data access.
    output logic o_en,
    output logic o_we,
    output logic [6:0] o_ofs,
    output logic [7:0] o_wd
);
    timeunit 1ns;
    timeprecision 1ns;
    // Everything idle at time zero.
    initial {o_adv, o_ld, o_intr, o_tgt, o_en, o_we, o_ofs, o_wd} = '0;
    // Each request is held for exactly one taking edge.
    task automatic pcc(input logic a, input logic l, input logic n, input logic [12:0] t);
        @(posedge i_ref_clk);
        {o_adv, o_ld, o_intr, o_tgt} <= {a, l, n, t};
        @(posedge i_ref_clk);
        {o_adv, o_ld, o_intr} <= 3'h0;
    endtask : pcc
    // Released data shows its inverse, so a stale byte never passes for a valid one.
    task automatic acc(input logic w, input logic [6:0] o, input logic [7:0] d);
        @(posedge i_ref_clk);
        {o_en, o_we, o_ofs, o_wd} <= {1'b1, w, o, d};
        @(posedge i_ref_clk);
        {o_en, o_we, o_wd} <= {2'h0, ~d};
    endtask : acc
endmodule : bma_core_model

/* File: tb/bma_map_props.sv */
/* Port checker for the address map.
   Assumes one clock domain; bound to every instance of the map. */
module bma_map_props
    import bma_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_pc_advance,
    input wire logic i_pc_load,
    input wire logic i_intr_accept,
    input wire logic i_access_en,
    input wire logic [6:0] i_opcode_addr,
    input wire logic [12:0] o_pc,
    input wire logic [10:0] o_fetch_addr,
    input wire logic [7:0] o_read_data,
    input wire logic [8:0] o_eff_addr,
    input wire logic [7:0] o_core_status,
    input wire logic o_periph_sel
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    // Data accesses are excluded where a program counter low write could override the controls.
    property p_fold; o_fetch_addr == o_pc[10:0]; endproperty
    a_fold: assert property (p_fold) else $error("fetch not folded");
    property p_rvec; $past(i_reset) |-> o_pc == RESET_VECTOR; endproperty
    a_rvec: assert property (p_rvec) else $error("reset vector");
    property p_ivec; i_intr_accept && !i_access_en |=> o_pc == INTR_VECTOR; endproperty
    a_ivec: assert property (p_ivec) else $error("interrupt vector");
    property p_adv; i_pc_advance && !i_pc_load && !i_intr_accept && !i_access_en |=> o_pc == $past(o_pc) + 13'h0001;
    endproperty
    a_adv: assert property (p_adv) else $error("pc step");
    property p_dir; i_access_en && i_opcode_addr != 7'h00
        |=> o_eff_addr == {$past(o_core_status[6:5]), $past(i_opcode_addr)}; endproperty
    a_dir: assert property (p_dir) else $error("direct address");
    property p_ind; i_access_en && i_opcode_addr == 7'h00 |=> o_eff_addr[8] == $past(o_core_status[7]); endproperty
    a_ind: assert property (p_ind) else $error("indirect bank");
    property p_per; i_access_en && i_opcode_addr inside {7'h01, [7'h05:7'h1f]} |=> o_periph_sel; endproperty
    a_per: assert property (p_per) else $error("peripheral select");
    property p_zero; $past(i_access_en) && o_eff_addr[8:7] != 2'h0 && o_eff_addr[6:0] inside {[7'h40:7'h6f]}
        |-> o_read_data == 8'h00; endproperty
    a_zero: assert property (p_zero) else $error("unimplemented not zero");
    c_int: cover property (i_intr_accept);
    c_ind: cover property (i_access_en && i_opcode_addr == 7'h00);
    c_per: cover property (o_periph_sel);
endmodule : bma_map_props
bind bma_address_map bma_map_props u_props (.*);

/* File: tb/tb_top.sv */
/* Top bench for the address map.
   Assumes the core model drives every design input except the clock and reset, which the bench drives. */
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; $display("ERROR %0t mismatch", $time); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_ref_clk = 1'b0, i_reset = 1'b1, adv, ld, intr, en, we, ps;
    logic [12:0] tgt, pc;
    logic [10:0] fa;
    logic [8:0] ea;
    logic [7:0] wd, rd, st;
    logic [6:0] ofs;
    int num_errors = 0, checked = 0;
    bma_core_model core (.i_ref_clk(i_ref_clk), .o_adv(adv), .o_ld(ld), .o_intr(intr), .o_tgt(tgt), .o_en(en),
        .o_we(we), .o_ofs(ofs), .o_wd(wd));
    bma_address_map uut (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_pc_advance(adv), .i_pc_load(ld),
        .i_pc_target(tgt), .i_intr_accept(intr), .i_access_en(en), .i_write_en(we), .i_opcode_addr(ofs),
        .i_write_data(wd), .o_pc(pc), .o_fetch_addr(fa), .o_read_data(rd), .o_eff_addr(ea),
        .o_core_status(st), .o_periph_sel(ps));
    // Clock at 10 MHz.
    initial forever #50 i_ref_clk = ~i_ref_clk;
    // Top of the counter wraps to zero; interrupt wins over a load.
    task automatic t_program;
        `CHK(pc, 13'h0000)
        `CHK(st, 8'h18)
        core.pcc(1'b0, 1'b1, 1'b0, 13'h1fff);
        #1 `CHK(fa, 11'h7ff)
        core.pcc(1'b1, 1'b0, 1'b0, 13'h0000);
        #1 `CHK(pc, 13'h0000)
        core.pcc(1'b1, 1'b1, 1'b1, 13'h0100);
        #1 `CHK(pc, 13'h0004)
    endtask : t_program
    // The common byte is seen from every bank and through the pointer.
    task automatic t_data;
        core.acc(1'b1, 7'h75, 8'h5a);
        for (int b = 0; b < 4; b++) begin
            core.acc(1'b1, 7'h03, {1'b0, 2'(b), 5'h1f});
            #1 `CHK(st, {1'b0, 2'(b), 5'h18})
            core.acc(1'b0, 7'h75, 8'h00);
            #1 `CHK({ea, rd}, {2'(b), 7'h75, 8'h5a})
        end
        core.acc(1'b0, 7'h50, 8'h00);
        #1 `CHK(rd, 8'h00)
        core.acc(1'b1, 7'h03, 8'h80);
        core.acc(1'b1, 7'h04, 8'h75);
        core.acc(1'b0, 7'h00, 8'h00);
        #1 `CHK({ea, rd}, {9'h175, 8'h5a})
        core.acc(1'b1, 7'h03, 8'hc0);
        core.acc(1'b0, 7'h04, 8'h00);
        #1 `CHK({ea, rd}, {9'h104, 8'h75})
        core.acc(1'b1, 7'h02, 8'h33);
        #1 `CHK(pc, 13'h0033)
        core.acc(1'b0, 7'h02, 8'h00);
        #1 `CHK(rd, 8'h33)
        core.acc(1'b0, 7'h05, 8'h00);
        #1 `CHK(ps, 1'b1)
    endtask : t_data
    // Bank 1 RAM is storage of its own; unimplemented bank 1 space drops writes and reads zero.
    task automatic t_ram;
        core.acc(1'b1, 7'h03, 8'h20);
        core.acc(1'b1, 7'h20, 8'ha1);
        core.acc(1'b1, 7'h40, 8'hc3);
        core.acc(1'b1, 7'h03, 8'h00);
        core.acc(1'b1, 7'h20, 8'hb2);
        core.acc(1'b0, 7'h20, 8'h00);
        #1 `CHK({ea, rd}, {9'h020, 8'hb2})
        core.acc(1'b1, 7'h03, 8'h20);
        core.acc(1'b0, 7'h20, 8'h00);
        #1 `CHK({ea, rd}, {9'h0a0, 8'ha1})
        core.acc(1'b0, 7'h40, 8'h00);
        #1 `CHK({ea, rd}, {9'h0c0, 8'h00})
    endtask : t_ram
    task automatic complete_run;
        if (num_errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run
    // Reset for two cycles, then run the scenarios.
    initial begin
        repeat (2) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        #1;
        t_program();
        t_data();
        t_ram();
        complete_run();
    end
endmodule : tb_top
